// file: svr_pkg.sv
/*
  Package for the sensor readout register bank: holding-register map,
  read function and exception codes, status-bit layout, alarm and
  current-loop scaling constants, carrier structs and the responder states.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package svr_pkg;
  // ----------------------------------------------------------------------
  // holding-register map, one 32-bit value per pair of registers
  // ----------------------------------------------------------------------
  localparam int NUM_VALUES = 7;
  localparam logic [15:0] REG_GAS_TEMPERATURE = 16'h0000;
  localparam logic [15:0] REG_OIL_VAPOR_CONTENT = 16'h0002;
  localparam logic [15:0] REG_LINE_PRESSURE = 16'h0004;
  localparam logic [15:0] REG_REMAINING_LAMP_LIFE = 16'h0006;
  localparam logic [15:0] REG_REMAINING_FILTER_CAPACITY = 16'h0008;
  localparam logic [15:0] REG_DEVICE_STATUS_WORD = 16'h000a;
  localparam logic [15:0] REG_RAW_SENSOR_OUTPUT = 16'h000c;
  localparam logic [15:0] REG_END = 16'h000e;
  localparam int IDX_STATUS = 5;
  // ----------------------------------------------------------------------
  // read function and exception answers
  // ----------------------------------------------------------------------
  localparam logic [7:0] FUNC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FUNC_EXCEPTION_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
  // ----------------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------------
  localparam int STATUS_WIDTH = 15;
  localparam int ST_BIT_ALARM = 0;
  localparam int ST_BIT_PRESSURE_LOW = 8;
  localparam int ST_BIT_SIGNAL_HIGH = 14;
  // ----------------------------------------------------------------------
  // content scale in ug/m3: 10.000 mg/m3 full scale, 1.0 mg/m3 alarm
  // ----------------------------------------------------------------------
  localparam logic [15:0] CONTENT_FULL_SCALE_UG = 16'h2710;
  localparam logic [15:0] ALARM_THRESHOLD_RESET_UG = 16'h03e8;
  // ----------------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic signal_high;
    logic signal_small;
    logic comm_failed;
    logic temp_high;
    logic temp_low;
    logic pressure_high;
    logic pressure_low;
    logic filter_exhausted;
    logic filter_soon;
    logic lamp_expired;
    logic lamp_soon;
    logic cal_overdue;
    logic cal_soon;
    logic over_range;
    logic alarm;
  } svr_status_s;

  typedef struct packed {
    logic [31:0] gas_temperature;
    logic [31:0] oil_vapor_content;
    logic [31:0] line_pressure;
    logic [31:0] remaining_lamp_life;
    logic [31:0] remaining_filter_capacity;
    logic [31:0] raw_sensor_output;
  } svr_meas_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FUNC = 2'b01,
    ST_COUNT = 2'b11,
    ST_DATA = 2'b10
  } svr_state_e;
endpackage
`default_nettype wire

// file: svr_readout.sv
/*
  Measurement and status register bank of an oil vapor sensor, answering
  read-holding-register requests byte by byte, plus the alarm relay, alarm
  LED and the current-loop code. Assumes a frame layer outside that parses
  requests, adds address and checksum, and a DAC that drives the loop.
*/
// Overview of operation
// - loop code runs linearly from 4 mA at zero to 20 mA at 10 mg/m3.
// - seven read-only 32-bit values on even register pairs from address zero.
// - status value at address ten is an unsigned word of independent flags.
// - master reads with function 03; answer carries the same function code.
// - each value goes low word first, each word high byte first.
// - status bits 0..7: alarm, over range, calibration, lamp and filter flags.
// - status bits 8..14: pressure, temperature, communication, signal level flags.
// - relay is normally open, so loss of power reads as alarm.
// - powered and below threshold: relay closed, alarm LED off.
// - powered and threshold reached: relay open, alarm LED on.
// - alarm threshold defaults to 1.0 mg/m3 until reconfigured.
`timescale 1ns/1ps
`default_nettype none
module svr_readout
  import svr_pkg::*;
#(
  parameter logic [15:0] LOOP_CODE_4MA = 16'h0ccc,
  parameter logic [15:0] LOOP_CODE_20MA = 16'hffff
)(
  // clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // measurements from the sensing core
  input wire logic MEAS_LOAD,
  input var svr_meas_s MEAS,
  input wire logic [15:0] CONTENT_UG,
  input var svr_status_s FLAGS,
  // alarm threshold setting
  input wire logic THRESH_WE,
  input wire logic [15:0] THRESH_UG,
  // read request from the frame layer
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [7:0] REQ_FUNC,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [15:0] REQ_QTY,
  // answer bytes to the frame layer
  output logic RSP_VALID,
  input wire logic RSP_READY,
  output logic [7:0] RSP_BYTE,
  output logic RSP_LAST,
  // field outputs
  output logic RELAY_CLOSE,
  output logic ALARM_LED,
  output logic [15:0] LOOP_CODE
);
  // ----------------------------------------------------------------------
  // value store and alarm
  // ----------------------------------------------------------------------
  logic [31:0] live [NUM_VALUES];
  logic [31:0] snap [NUM_VALUES];
  logic [15:0] threshold;
  logic [15:0] content;
  logic relay_close;
  logic alarm_led;
  logic [15:0] loop_code;
  logic [15:0] next_threshold;
  logic [15:0] next_content;
  logic next_relay_close;
  logic next_alarm_led;
  logic [15:0] next_loop_code;
  logic alarm_now;
  logic [31:0] status_word;
  logic [31:0] loop_prod;
  logic [31:0] loop_quot;

  assign alarm_now = content >= threshold;
  // unused upper bits stay zero; bit 0 is this block's own comparison
  assign status_word = {17'h0_0000, FLAGS[STATUS_WIDTH-1:1], alarm_now};

  always_comb
  begin
    next_threshold = threshold;
    next_content = content;
    if (THRESH_WE)
    begin
      next_threshold = THRESH_UG;
    end
    if (MEAS_LOAD)
    begin
      next_content = CONTENT_UG;
    end
    next_relay_close = !alarm_now;
    next_alarm_led = alarm_now;
    loop_prod = {16'h0000, content} * {16'h0000, LOOP_CODE_20MA - LOOP_CODE_4MA};
    loop_quot = loop_prod / {16'h0000, CONTENT_FULL_SCALE_UG};
    // clamp above full scale rather than wrap the loop code
    if (content >= CONTENT_FULL_SCALE_UG)
    begin
      next_loop_code = LOOP_CODE_20MA;
    end
    else
    begin
      next_loop_code = LOOP_CODE_4MA + loop_quot[15:0];
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      threshold <= ALARM_THRESHOLD_RESET_UG;
      content <= 16'h0000;
      relay_close <= 1'b0;
      alarm_led <= 1'b0;
      loop_code <= LOOP_CODE_4MA;
    end
    else if (CE)
    begin
      threshold <= next_threshold;
      content <= next_content;
      relay_close <= next_relay_close;
      alarm_led <= next_alarm_led;
      loop_code <= next_loop_code;
    end
  end

  // live values; status is not stored here but taken from FLAGS and the alarm comparison at accept
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < NUM_VALUES; i++)
      begin
        live[i] <= 32'h0000_0000;
      end
    end
    else if (CE && MEAS_LOAD)
    begin
      live[0] <= MEAS.gas_temperature;
      live[1] <= MEAS.oil_vapor_content;
      live[2] <= MEAS.line_pressure;
      live[3] <= MEAS.remaining_lamp_life;
      live[4] <= MEAS.remaining_filter_capacity;
      live[6] <= MEAS.raw_sensor_output;
    end
  end

  assign RELAY_CLOSE = relay_close;
  assign ALARM_LED = alarm_led;
  assign LOOP_CODE = loop_code;

  // ----------------------------------------------------------------------
  // read responder
  // ----------------------------------------------------------------------
  svr_state_e state;
  svr_state_e next_state;
  logic [15:0] start;
  logic [4:0] idx;
  logic [4:0] last_idx;
  logic exc;
  logic [7:0] rsp_byte;
  logic [15:0] next_start;
  logic [4:0] next_idx;
  logic [4:0] next_last_idx;
  logic next_exc;
  logic [7:0] next_rsp_byte;
  logic accept;
  logic step;
  logic req_legal;
  logic req_range_ok;
  logic [16:0] req_end;

  // byte k of an answer starting at register base; one value is two registers
  function automatic logic [7:0] answer_byte(input logic [15:0] base, input logic [4:0] k,
                                             input logic [31:0] val);
    logic [15:0] reg_addr;
    logic [15:0] word;
    reg_addr = base + {12'h000, k[4:1]};
    word = reg_addr[0] ? val[31:16] : val[15:0];
    answer_byte = k[0] ? word[7:0] : word[15:8];
  endfunction

  function automatic logic [2:0] value_of(input logic [15:0] base, input logic [4:0] k);
    logic [15:0] reg_addr;
    reg_addr = base + {12'h000, k[4:1]};
    value_of = reg_addr[3:1];
  endfunction

  assign REQ_READY = state == ST_IDLE;
  assign RSP_VALID = state != ST_IDLE;
  assign RSP_BYTE = rsp_byte;
  assign RSP_LAST = (state == ST_COUNT && exc) || (state == ST_DATA && idx == last_idx);
  assign accept = CE && REQ_VALID && state == ST_IDLE;
  assign step = CE && RSP_VALID && RSP_READY;
  assign req_end = {1'b0, REQ_ADDR} + {1'b0, REQ_QTY};
  assign req_range_ok = REQ_QTY != 16'h0000 && req_end <= {1'b0, REG_END};
  assign req_legal = REQ_FUNC == FUNC_READ_HOLDING && req_range_ok;

  always_comb
  begin
    next_state = state;
    next_start = start;
    next_idx = idx;
    next_last_idx = last_idx;
    next_exc = exc;
    next_rsp_byte = rsp_byte;
    case (state)
      ST_IDLE:
      begin
        if (accept)
        begin
          next_state = ST_FUNC;
          next_start = REQ_ADDR;
          next_idx = 5'h00;
          next_last_idx = 5'(REQ_QTY * 2 - 1);
          next_exc = !req_legal;
          // the answer echoes the code it was asked with
          next_rsp_byte = req_legal ? REQ_FUNC : (REQ_FUNC | FUNC_EXCEPTION_FLAG);
        end
      end
      ST_FUNC:
      begin
        if (step)
        begin
          next_state = ST_COUNT;
          if (exc)
          begin
            next_rsp_byte = (rsp_byte == (FUNC_READ_HOLDING | FUNC_EXCEPTION_FLAG))
                            ? EXC_ILLEGAL_ADDRESS : EXC_ILLEGAL_FUNCTION;
          end
          else
          begin
            next_rsp_byte = {3'b000, last_idx} + 8'h01;
          end
        end
      end
      ST_COUNT:
      begin
        if (step)
        begin
          next_state = exc ? ST_IDLE : ST_DATA;
          next_rsp_byte = exc ? 8'h00 : answer_byte(start, 5'h00, snap[value_of(start, 5'h00)]);
        end
      end
      ST_DATA:
      begin
        if (step)
        begin
          next_idx = idx + 5'h01;
          next_rsp_byte = (idx == last_idx) ? 8'h00
                          : answer_byte(start, next_idx, snap[value_of(start, next_idx)]);
          if (idx == last_idx)
          begin
            next_state = ST_IDLE;
          end
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state <= ST_IDLE;
      start <= 16'h0000;
      idx <= 5'h00;
      last_idx <= 5'h00;
      exc <= 1'b0;
      rsp_byte <= 8'h00;
    end
    else if (CE)
    begin
      state <= next_state;
      start <= next_start;
      idx <= next_idx;
      last_idx <= next_last_idx;
      exc <= next_exc;
      rsp_byte <= next_rsp_byte;
    end
  end

  // snapshot on accept, so no value tears between its two words mid-answer
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < NUM_VALUES; i++)
      begin
        snap[i] <= 32'h0000_0000;
      end
    end
    else if (accept)
    begin
      for (int i = 0; i < NUM_VALUES; i++)
      begin
        snap[i] <= (i == IDX_STATUS) ? status_word : live[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence legal_read_s;
    accept && REQ_FUNC == FUNC_READ_HOLDING && req_range_ok;
  endsequence

  sequence head_sent_s;
    state == ST_FUNC && rsp_byte == FUNC_READ_HOLDING && !exc;
  endsequence

  func_echo_a: assert property (@(posedge REF_CLK) disable iff (RST)
    legal_read_s |=> head_sent_s)
    else $error("read answer does not open with function 03");

  bad_range_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (accept && REQ_FUNC == FUNC_READ_HOLDING && REQ_ADDR >= REG_END) |=> exc ##0 rsp_byte == 8'h83)
    else $error("out-of-map read not answered as exception");

  first_byte_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (state == ST_COUNT && !exc && step && start[0] == 1'b0)
    |=> rsp_byte == snap[start[3:1]][15:8])
    else $error("first data byte is not the high byte of the low word");

  status_upper_a: assert property (@(posedge REF_CLK) disable iff (RST)
    accept |=> snap[IDX_STATUS][31:STATUS_WIDTH] == 17'h0_0000)
    else $error("undefined status bits are not zero");

  status_alarm_a: assert property (@(posedge REF_CLK) disable iff (RST)
    accept |=> snap[IDX_STATUS][ST_BIT_ALARM] == $past(alarm_now))
    else $error("status bit 0 does not follow the alarm comparison");

  status_press_a: assert property (@(posedge REF_CLK) disable iff (RST)
    accept |=> snap[IDX_STATUS][ST_BIT_SIGNAL_HIGH:ST_BIT_PRESSURE_LOW]
      == $past(FLAGS[ST_BIT_SIGNAL_HIGH:ST_BIT_PRESSURE_LOW]))
    else $error("status bits 8..14 misplaced");

  relay_quiet_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (CE && !alarm_now) |=> RELAY_CLOSE && !ALARM_LED)
    else $error("relay not closed or LED lit below threshold");

  relay_alarm_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (CE && alarm_now) |=> !RELAY_CLOSE && ALARM_LED)
    else $error("relay not open or LED dark at threshold");

  relay_off_a: assert property (@(posedge REF_CLK)
    RST |=> !RELAY_CLOSE)
    else $error("relay closed while held in reset");

  thresh_default_a: assert property (@(posedge REF_CLK)
    RST |=> threshold == ALARM_THRESHOLD_RESET_UG)
    else $error("alarm threshold not 1.0 mg/m3 after reset");

  loop_ends_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (CE && content == 16'h0000) |=> LOOP_CODE == LOOP_CODE_4MA)
    else $error("loop code not at 4 mA for zero content");

  loop_full_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (CE && content >= CONTENT_FULL_SCALE_UG) |=> LOOP_CODE == LOOP_CODE_20MA)
    else $error("loop code not at 20 mA at full scale");
endmodule
`default_nettype wire

// file: svr_master_model.sv
/*
  Field-bus master model: presents one read request at a time and drains
  the answer bytes, stalling by a pattern from the bench.
  Assumes a bench that calls xfer and reads rx, n and get_val afterwards.
*/
`timescale 1ns/1ps
`default_nettype none
module svr_master_model (
  // clock
  input wire logic REF_CLK,
  // request side
  output logic REQ_VALID,
  input wire logic REQ_READY,
  output logic [7:0] REQ_FUNC,
  output logic [15:0] REQ_ADDR,
  output logic [15:0] REQ_QTY,
  // answer side
  input wire logic RSP_VALID,
  output logic RSP_READY,
  input wire logic [7:0] RSP_BYTE,
  input wire logic RSP_LAST,
  // stall pattern, one bit per cycle
  input wire logic [7:0] STALL
);
  logic [7:0] rx [0:31];
  int n;
  int to;
  bit done;
  int k;

  initial
  begin
    REQ_VALID = 1'b0;
    REQ_FUNC = 8'h00;
    REQ_ADDR = 16'h0000;
    REQ_QTY = 16'h0000;
    RSP_READY = 1'b0;
    n = 0;
  end

  // master order is big-endian: words come low first, so swap them back
  function automatic logic [31:0] get_val(input int i);
    return {rx[i + 2], rx[i + 3], rx[i], rx[i + 1]};
  endfunction

  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q);
    n = 0;
    to = 0;
    k = 0;
    done = 1'b0;
    @(posedge REF_CLK);
    #1;
    REQ_VALID = 1'b1;
    REQ_FUNC = f;
    REQ_ADDR = a;
    REQ_QTY = q;
    while (REQ_READY !== 1'b1 && to < 50)
    begin
      @(posedge REF_CLK);
      #1;
      to++;
    end
    @(posedge REF_CLK);
    #1;
    // released lines carry junk so a stale value is never mistaken for data
    REQ_VALID = 1'b0;
    REQ_FUNC = ~f;
    REQ_ADDR = ~a;
    REQ_QTY = ~q;
    while (!done && to < 300)
    begin
      RSP_READY = STALL[k % 8];
      k++;
      #1;
      if (RSP_VALID === 1'b1 && RSP_READY && n < 32)
      begin
        rx[n] = RSP_BYTE;
        n++;
        done = (RSP_LAST === 1'b1);
      end
      @(posedge REF_CLK);
      #1;
      to++;
    end
    RSP_READY = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
/*
  Self-checking bench for the sensor readout bank: alarm and loop sweeps,
  reads of all value pairs, exception answers and resets.
  Assumes the master model file is compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import svr_pkg::*;
  localparam logic [15:0] L4 = 16'h0ccc;
  localparam logic [15:0] L20 = 16'hffff;
  logic ref_clk, rst, ce, meas_load, thresh_we, req_valid, req_ready;
  logic rsp_valid, rsp_ready, rsp_last, relay_close, alarm_led;
  logic [7:0] req_func, rsp_byte, stall;
  logic [15:0] content_ug, thresh_ug, req_addr, req_qty, loop_code, cur_c, cur_t;
  svr_meas_s meas;
  svr_status_s flags;
  integer seed;
  int errors, checked;

  svr_readout #(.LOOP_CODE_4MA(L4), .LOOP_CODE_20MA(L20)) dut_u (.REF_CLK(ref_clk),
    .RST(rst), .CE(ce), .MEAS_LOAD(meas_load), .MEAS(meas), .CONTENT_UG(content_ug),
    .FLAGS(flags), .THRESH_WE(thresh_we), .THRESH_UG(thresh_ug), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_FUNC(req_func), .REQ_ADDR(req_addr), .REQ_QTY(req_qty),
    .RSP_VALID(rsp_valid), .RSP_READY(rsp_ready), .RSP_BYTE(rsp_byte),
    .RSP_LAST(rsp_last), .RELAY_CLOSE(relay_close), .ALARM_LED(alarm_led),
    .LOOP_CODE(loop_code));

  svr_master_model m_u (.REF_CLK(ref_clk), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_FUNC(req_func), .REQ_ADDR(req_addr), .REQ_QTY(req_qty), .RSP_VALID(rsp_valid),
    .RSP_READY(rsp_ready), .RSP_BYTE(rsp_byte), .RSP_LAST(rsp_last), .STALL(stall));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------------
  // checking and expectations
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [15:0] exp_loop(input logic [15:0] c);
    logic [31:0] p;
    if (c >= CONTENT_FULL_SCALE_UG)
      return L20;
    p = 32'(c) * 32'(L20 - L4) / 32'(CONTENT_FULL_SCALE_UG);
    return L4 + p[15:0];
  endfunction

  function automatic logic [31:0] exp_val(input int i);
    case (i)
      0: return meas.gas_temperature;
      1: return meas.oil_vapor_content;
      2: return meas.line_pressure;
      3: return meas.remaining_lamp_life;
      4: return meas.remaining_filter_capacity;
      IDX_STATUS: return {17'h00000, flags[14:1], cur_c >= cur_t};
      default: return meas.raw_sensor_output;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------------
  task automatic do_reset;
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("relay_in_reset", relay_close, 1'b0);
    check("led_in_reset", alarm_led, 1'b0);
    rst = 1'b0;
    cur_c = 16'h0000;
    cur_t = ALARM_THRESHOLD_RESET_UG;
    @(posedge ref_clk);
    #1;
    check("relay_idle", relay_close, 1'b1);
    check("loop_zero", loop_code, L4);
    $display("test reset done");
  endtask

  task automatic set_content(input logic [15:0] c);
    @(posedge ref_clk);
    #1;
    content_ug = c;
    meas = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
      $random(seed)};
    flags = 15'($random(seed));
    meas_load = 1'b1;
    @(posedge ref_clk);
    #1;
    meas_load = 1'b0;
    cur_c = c;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic sweep;
    logic [15:0] corner [0:3];
    logic [15:0] c;
    corner = '{cur_t - 16'h0001, cur_t, CONTENT_FULL_SCALE_UG, 16'h0000};
    for (int i = 0; i < 10; i++)
    begin
      c = (i < 4) ? corner[i] : 16'($unsigned($random(seed)) % 32'h2ee0);
      set_content(c);
      check("relay", relay_close, c < cur_t);
      check("led", alarm_led, c >= cur_t);
      check("loop", loop_code, exp_loop(c));
    end
    $display("test sweep done");
  endtask

  task automatic rd(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q);
    logic [31:0] v;
    logic [15:0] w;
    int b;
    stall = 8'($random(seed)) | 8'h01;
    m_u.xfer(f, a, q);
    if (f !== FUNC_READ_HOLDING || q == 16'h0000 || a + q > REG_END)
    begin
      check("exc_len", m_u.n, 2);
      check("exc_func", m_u.rx[0], f | FUNC_EXCEPTION_FLAG);
      check("exc_code", m_u.rx[1], (f === FUNC_READ_HOLDING) ? EXC_ILLEGAL_ADDRESS
        : EXC_ILLEGAL_FUNCTION);
      return;
    end
    check("len", m_u.n, 2 + 2 * q);
    check("func", m_u.rx[0], FUNC_READ_HOLDING);
    check("count", m_u.rx[1], 2 * q);
    for (int r = a; r < a + q; r++)
    begin
      v = exp_val(r / 2);
      w = r[0] ? v[31:16] : v[15:0];
      b = 2 + 2 * (r - a);
      check("hi_byte", m_u.rx[b], w[15:8]);
      check("lo_byte", m_u.rx[b + 1], w[7:0]);
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    #500000;
    errors++;
    wrap_up();
  end

  initial
  begin
    int a;
    seed = 32'hda60;
    errors = 0;
    checked = 0;
    rst = 1'b1;
    ce = 1'b1;
    meas_load = 1'b0;
    thresh_we = 1'b0;
    thresh_ug = 16'h0000;
    content_ug = 16'h0000;
    meas = '0;
    flags = '0;
    stall = 8'hff;
    do_reset();
    sweep();
    set_content(cur_t);
    rd(FUNC_READ_HOLDING, REG_GAS_TEMPERATURE, 16'h000e);
    for (int i = 0; i < NUM_VALUES; i++)
      check("value", m_u.get_val(2 + 4 * i), exp_val(i));
    for (int i = 0; i < 16; i++)
    begin
      a = $unsigned($random(seed)) % 14;
      rd(FUNC_READ_HOLDING, 16'(a), 16'(1 + $unsigned($random(seed)) % (14 - a)));
    end
    rd(FUNC_READ_HOLDING, REG_DEVICE_STATUS_WORD, 16'h0002);
    rd(8'h04, REG_GAS_TEMPERATURE, 16'h0001);
    rd(8'h10, REG_GAS_TEMPERATURE, 16'h0001);
    rd(FUNC_READ_HOLDING, REG_GAS_TEMPERATURE, 16'h0000);
    rd(FUNC_READ_HOLDING, REG_RAW_SENSOR_OUTPUT, 16'h0003);
    rd(FUNC_READ_HOLDING, REG_END, 16'h0001);
    $display("test reads done");
    @(posedge ref_clk);
    #1;
    thresh_ug = 16'h07d0;
    thresh_we = 1'b1;
    @(posedge ref_clk);
    #1;
    thresh_we = 1'b0;
    cur_t = 16'h07d0;
    sweep();
    // a threshold write with the enable low must not land
    ce = 1'b0;
    thresh_ug = 16'h0001;
    thresh_we = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    thresh_we = 1'b0;
    ce = 1'b1;
    set_content(cur_t - 16'h0001);
    check("ce_freeze", relay_close, 1'b1);
    rd(FUNC_READ_HOLDING, REG_DEVICE_STATUS_WORD, 16'h0002);
    do_reset();
    sweep();
    wrap_up();
  end
endmodule
`default_nettype wire
